/* File: shared/tsf_pkg.sv */
// Constants, field positions and state types for the filter B register port
package tsf_pkg;
	// ==========================================================
	// Register byte offsets
	localparam logic [11:0] OFF_FILTER_PORT = 12'h0DC;
	localparam logic [11:0] OFF_FILTER_CSR  = 12'h0E0;
	localparam logic [11:0] OFF_INS_PORT    = 12'h0E4;
	localparam logic [11:0] OFF_INS_CTRL    = 12'h0E8;
	// ==========================================================
	// Filter control and status fields
	localparam int CSR_ON_BIT   = 0;
	localparam int CSR_CLR_BIT  = 1;
	localparam int CSR_DEST_LO  = 4;
	localparam int CSR_WR_LO    = 8;
	localparam int CSR_RD_LO    = 12;
	// ==========================================================
	// Insertion control fields
	localparam int INS_SIZE_LO    = 0;
	localparam int INS_ON_BIT     = 6;
	localparam int INS_DEST_LO    = 8;
	localparam int INS_RD_LO      = 16;
	localparam int INS_RDRST_BIT  = 22;
	localparam int INS_WR_LO      = 24;
	localparam int INS_WRRST_BIT  = 30;
	// ==========================================================
	// Widths, depths and reset values
	localparam int DATA_W       = 32;
	localparam int PID_W        = 13;
	localparam int BUF_W        = 3;
	localparam int TABLE_DEPTH  = 16;
	localparam int TABLE_PTR_W  = 4;
	localparam int INS_DEPTH    = 64;
	localparam int INS_PTR_W    = 6;
	localparam int FIFO_DEPTH   = 8;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	// ==========================================================
	// Insertion sequencer states
	typedef enum logic [0:0]
	{
		INS_IDLE = 1'b0,
		INS_SEND = 1'b1
	} ins_state_t;
endpackage

/* File: logic/pid_table.sv */
// Sixteen-entry identifier comparison table with clear, write and match
`timescale 1ns/1ps
module pid_table
(
	input  wire logic        clock,    // System clock
	input  wire logic        resetn,   // Synchronous reset, active low
	input  wire logic        clear,    // Zero every entry
	input  wire logic        wr_en,    // Write one entry
	input  wire logic [3:0]  wr_addr,  // Entry written
	input  wire logic [31:0] wr_data,  // Value written
	input  wire logic [3:0]  rd_addr,  // Entry read
	output logic      [31:0] rd_data,  // Entry at rd_addr
	input  wire logic [12:0] pid,      // Identifier under test
	output logic             match     // Some entry equals pid
);
	// ==========================================================
	// Entries
	logic [31:0] entry [0:tsf_pkg::TABLE_DEPTH-1];
	logic [tsf_pkg::TABLE_DEPTH-1:0] hit;

	genvar i;
	generate
		for (i = 0; i < tsf_pkg::TABLE_DEPTH; i++)
		begin : g_entry
			// Clear beats a write in the same cycle
			always_ff @(posedge clock)
			begin
				if (!resetn || clear)
					entry[i] <= tsf_pkg::REG_RESET;
				else if (wr_en && wr_addr == 4'(i))
					entry[i] <= wr_data;
			end
			// Only the low identifier bits take part in the compare
			assign hit[i] = (entry[i][tsf_pkg::PID_W-1:0] == pid);
		end
	endgenerate

	// Read and match views
	assign rd_data = entry[rd_addr];
	assign match   = |hit;
endmodule // pid_table

/* File: logic/stream_fifo.sv */
// Small FIFO with registered output stage and registered ready
`timescale 1ns/1ps
module stream_fifo
#(
	parameter int WIDTH = 35,
	parameter int DEPTH = 8
)
(
	input  wire logic             clock,     // System clock
	input  wire logic             resetn,    // Synchronous reset, active low
	input  wire logic             in_valid,  // Push request
	output logic                  in_ready,  // Room for a push
	output logic                  room_next, // Room after this cycle
	input  wire logic [WIDTH-1:0] in_data,   // Pushed word
	output logic                  out_valid, // Output word held
	input  wire logic             out_ready, // Drain accepts word
	output logic      [WIDTH-1:0] out_data   // Output word
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

	// ==========================================================
	// Storage and pointers
	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW:0]      count;
	logic [PW:0]      next_count;
	logic             push;
	logic             pop;

	assign push       = in_valid && in_ready;
	assign pop        = (count != '0) && (!out_valid || out_ready);
	assign next_count = count + (PW+1)'(push) - (PW+1)'(pop);
	assign room_next  = (next_count != FULL);

	// Ready is registered so the upstream sees a clean level
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			wr_ptr   <= '0;
			rd_ptr   <= '0;
			count    <= '0;
			in_ready <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			count    <= next_count;
			in_ready <= room_next;
		end
	end

	// Memory needs no reset; count guards every read
	always_ff @(posedge clock)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// Output stage refills whenever it is empty or drained
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end
		else if (pop)
		begin
			out_valid <= 1'b1;
			out_data  <= mem[rd_ptr];
		end
		else if (out_ready)
			out_valid <= 1'b0;
	end
endmodule // stream_fifo

/* File: logic/pid_filter_b_port.sv */
// Filter B control, table access, insertion RAM port and accepted-packet path
//
// What this block does
// - Reserved control bits ignore writes, read zero.
// - Read pointer advances per table read while off.
// - Turning filter on zeroes read pointer.
// - Table reads while on keep read pointer.
// - Write pointer advances per table write while off.
// - Write pointer held zero while filter on.
// - Destination field picks one of eight buffers.
// - Clear bit zeroes table and both pointers.
// - When on, only packets whose first-word identifier matches pass.
// - Insertion port writes store at write pointer.
// - Insertion writes while disabled advance pointer.
// - Insertion port inert while insertion enabled.
// - Insertion RAM never cleared or initialised.
// - Table port reads entry, writes when off.
// - Insertion enable zeroes pointers, self-clears after.
`timescale 1ns/1ps
module pid_filter_b_port
(
	input  wire logic        clock,       // 25 MHz system clock
	input  wire logic        resetn,      // Synchronous reset, active low
	input  wire logic [11:0] host_addr,   // Register byte address
	input  wire logic        host_wr,     // Write strobe, one cycle
	input  wire logic        host_rd,     // Read strobe, one cycle
	input  wire logic [31:0] host_wdata,  // Write data
	output logic      [31:0] host_rdata,  // Read data, held
	output logic             host_rvalid, // Read data valid pulse
	input  wire logic        in_valid,    // Stream word present
	output logic             in_ready,    // Stream word taken
	input  wire logic        in_first,    // First word of packet
	input  wire logic        in_last,     // Last word of packet
	input  wire logic [12:0] in_pid,      // Packet identifier
	input  wire logic [31:0] in_data,     // Stream word
	output logic             out_valid,   // Buffer word present
	input  wire logic        out_ready,   // Buffer takes word
	output logic      [31:0] out_data,    // Buffer word
	output logic      [2:0]  out_buffer   // Target data buffer
);
	// ==========================================================
	// Register decode
	logic rd_tbl;
	logic wr_tbl;
	logic wr_csr;
	logic rd_ins;
	logic wr_ins;
	logic wr_ictl;

	assign rd_tbl  = host_rd && (host_addr == tsf_pkg::OFF_FILTER_PORT);
	assign wr_tbl  = host_wr && (host_addr == tsf_pkg::OFF_FILTER_PORT);
	assign wr_csr  = host_wr && (host_addr == tsf_pkg::OFF_FILTER_CSR);
	assign rd_ins  = host_rd && (host_addr == tsf_pkg::OFF_INS_PORT);
	assign wr_ins  = host_wr && (host_addr == tsf_pkg::OFF_INS_PORT);
	assign wr_ictl = host_wr && (host_addr == tsf_pkg::OFF_INS_CTRL);

	// ==========================================================
	// Filter control
	logic                        filter_on;
	logic [tsf_pkg::BUF_W-1:0]   accept_destination_buffer;
	logic [tsf_pkg::TABLE_PTR_W-1:0] table_read_pointer;
	logic [tsf_pkg::TABLE_PTR_W-1:0] table_write_pointer;
	logic                        filter_table_clear;
	logic                        turn_on;

	// The clear bit is a pulse only, so it always reads back as zero
	assign filter_table_clear = wr_csr && host_wdata[tsf_pkg::CSR_CLR_BIT];
	assign turn_on = wr_csr && host_wdata[tsf_pkg::CSR_ON_BIT] && !filter_on;

	// Enable and destination; reserved bits have no storage
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			filter_on                 <= 1'b0;
			accept_destination_buffer <= '0;
		end
		else if (wr_csr)
		begin
			filter_on                 <= host_wdata[tsf_pkg::CSR_ON_BIT];
			accept_destination_buffer <= host_wdata[tsf_pkg::CSR_DEST_LO +: tsf_pkg::BUF_W];
		end
	end

	// Read pointer: zeroed by clear or enable, frozen while on
	always_ff @(posedge clock)
	begin
		if (!resetn)
			table_read_pointer <= '0;
		else if (filter_table_clear)
			table_read_pointer <= '0;
		else if (turn_on)
			table_read_pointer <= '0;
		else if (rd_tbl && !filter_on)
			table_read_pointer <= table_read_pointer + 1'b1;
	end

	// Write pointer: held at zero whenever the filter runs
	always_ff @(posedge clock)
	begin
		if (!resetn)
			table_write_pointer <= '0;
		else if (filter_table_clear || filter_on || turn_on)
			table_write_pointer <= '0;
		else if (wr_tbl)
			table_write_pointer <= table_write_pointer + 1'b1;
	end

	// ==========================================================
	// Filter table
	logic [31:0] table_rd_data;
	logic        pid_match;

	pid_table u_table
	(
		.clock   (clock),
		.resetn  (resetn),
		.clear   (filter_table_clear),
		.wr_en   (wr_tbl && !filter_on),
		.wr_addr (table_write_pointer),
		.wr_data (host_wdata),
		.rd_addr (table_read_pointer),
		.rd_data (table_rd_data),
		.pid     (in_pid),
		.match   (pid_match)
	);

	// ==========================================================
	// Insertion control and RAM
	logic                          insertion_on;
	logic [tsf_pkg::INS_PTR_W-1:0] ins_wr_ptr;
	logic [tsf_pkg::INS_PTR_W-1:0] ins_rd_ptr;
	logic [tsf_pkg::INS_PTR_W-1:0] ins_size;
	logic [tsf_pkg::BUF_W-1:0]     ins_dest;
	logic [31:0]                   ins_ram [0:tsf_pkg::INS_DEPTH-1];
	logic                          ins_set;
	logic                          ins_push;
	logic                          ins_last;
	logic                          fifo_in_ready;
	tsf_pkg::ins_state_t           state;
	tsf_pkg::ins_state_t           next_state;

	assign ins_set  = wr_ictl && host_wdata[tsf_pkg::INS_ON_BIT] && !insertion_on;
	assign ins_push = (state == tsf_pkg::INS_SEND) && fifo_in_ready;
	assign ins_last = ins_push && (ins_rd_ptr + 1'b1 == ins_size);

	// Software write wins over the hardware clear in the same cycle
	always_ff @(posedge clock)
	begin
		if (!resetn)
			insertion_on <= 1'b0;
		else if (wr_ictl)
			insertion_on <= host_wdata[tsf_pkg::INS_ON_BIT];
		else if (ins_last)
			insertion_on <= 1'b0;
	end

	// Size and target buffer of the inserted packet
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			ins_size <= '0;
			ins_dest <= '0;
		end
		else if (wr_ictl)
		begin
			ins_size <= host_wdata[tsf_pkg::INS_SIZE_LO +: tsf_pkg::INS_PTR_W];
			ins_dest <= host_wdata[tsf_pkg::INS_DEST_LO +: tsf_pkg::BUF_W];
		end
	end

	// Write pointer wraps naturally at sixty-four words
	always_ff @(posedge clock)
	begin
		if (!resetn)
			ins_wr_ptr <= '0;
		else if (ins_set)
			ins_wr_ptr <= '0;
		else if (!insertion_on)
		begin
			if (wr_ictl && host_wdata[tsf_pkg::INS_WRRST_BIT])
				ins_wr_ptr <= '0;
			else if (wr_ins)
				ins_wr_ptr <= ins_wr_ptr + 1'b1;
		end
	end

	// Read pointer follows the hardware while inserting
	always_ff @(posedge clock)
	begin
		if (!resetn)
			ins_rd_ptr <= '0;
		else if (ins_set)
			ins_rd_ptr <= '0;
		else if (insertion_on)
		begin
			if (ins_push)
				ins_rd_ptr <= ins_rd_ptr + 1'b1;
		end
		else if (wr_ictl && host_wdata[tsf_pkg::INS_RDRST_BIT])
			ins_rd_ptr <= '0;
		else if (rd_ins)
			ins_rd_ptr <= ins_rd_ptr + 1'b1;
	end

	// No reset: contents are undefined until the host loads them
	always_ff @(posedge clock)
	begin
		if (wr_ins && !insertion_on)
			ins_ram[ins_wr_ptr] <= host_wdata;
	end

	// ==========================================================
	// Stream acceptance
	logic mid_packet;
	logic next_mid_packet;
	logic accept_lat;
	logic accept_now;
	logic push_stream;

	assign push_stream = in_valid && in_ready;
	// Decision is taken on the first word and held for the packet
	assign accept_now  = in_first ? (!filter_on || pid_match) : accept_lat;
	assign next_mid_packet = push_stream ? !in_last : mid_packet;

	// Packet tracking
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			mid_packet <= 1'b0;
			accept_lat <= 1'b0;
		end
		else
		begin
			mid_packet <= next_mid_packet;
			if (push_stream && in_first)
				accept_lat <= accept_now;
		end
	end

	// Insertion waits for a packet boundary so streams never interleave
	always_comb
	begin
		next_state = state;
		unique case (state)
			tsf_pkg::INS_IDLE:
				if (insertion_on && !next_mid_packet)
					next_state = tsf_pkg::INS_SEND;
			tsf_pkg::INS_SEND:
				if (ins_last || !insertion_on)
					next_state = tsf_pkg::INS_IDLE;
		endcase
	end

	// Sequencer state and registered stream ready
	logic fifo_room_next;
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			state    <= tsf_pkg::INS_IDLE;
			in_ready <= 1'b0;
		end
		else
		begin
			state    <= next_state;
			in_ready <= fifo_room_next && (next_state == tsf_pkg::INS_IDLE);
		end
	end

	// ==========================================================
	// Output buffer
	logic        fifo_push;
	logic [34:0] fifo_in;
	logic [34:0] fifo_out;

	assign fifo_push = ins_push || (push_stream && accept_now);
	assign fifo_in   = ins_push ? {ins_dest, ins_ram[ins_rd_ptr]}
	                            : {accept_destination_buffer, in_data};

	stream_fifo
	#(
		.WIDTH (tsf_pkg::BUF_W + tsf_pkg::DATA_W),
		.DEPTH (tsf_pkg::FIFO_DEPTH)
	)
	u_fifo
	(
		.clock     (clock),
		.resetn    (resetn),
		.in_valid  (fifo_push),
		.in_ready  (fifo_in_ready),
		.room_next (fifo_room_next),
		.in_data   (fifo_in),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_data  (fifo_out)
	);

	assign out_data   = fifo_out[tsf_pkg::DATA_W-1:0];
	assign out_buffer = fifo_out[34:tsf_pkg::DATA_W];

	// ==========================================================
	// Read views
	logic [31:0] csr_view;
	logic [31:0] ictl_view;

	always_comb
	begin
		csr_view = tsf_pkg::REG_RESET;
		csr_view[tsf_pkg::CSR_ON_BIT] = filter_on;
		csr_view[tsf_pkg::CSR_DEST_LO +: tsf_pkg::BUF_W] = accept_destination_buffer;
		csr_view[tsf_pkg::CSR_WR_LO +: tsf_pkg::TABLE_PTR_W] = table_write_pointer;
		csr_view[tsf_pkg::CSR_RD_LO +: tsf_pkg::TABLE_PTR_W] = table_read_pointer;
		ictl_view = tsf_pkg::REG_RESET;
		ictl_view[tsf_pkg::INS_SIZE_LO +: tsf_pkg::INS_PTR_W] = ins_size;
		ictl_view[tsf_pkg::INS_ON_BIT] = insertion_on;
		ictl_view[tsf_pkg::INS_DEST_LO +: tsf_pkg::BUF_W] = ins_dest;
		ictl_view[tsf_pkg::INS_RD_LO +: tsf_pkg::INS_PTR_W] = ins_rd_ptr;
		ictl_view[tsf_pkg::INS_WR_LO +: tsf_pkg::INS_PTR_W] = ins_wr_ptr;
	end

	// Read data is registered; unmapped addresses answer zero
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			host_rdata  <= tsf_pkg::REG_RESET;
			host_rvalid <= 1'b0;
		end
		else
		begin
			host_rvalid <= host_rd;
			if (host_rd)
			begin
				unique case (host_addr)
					tsf_pkg::OFF_FILTER_PORT: host_rdata <= table_rd_data;
					tsf_pkg::OFF_FILTER_CSR:  host_rdata <= csr_view;
					tsf_pkg::OFF_INS_PORT:    host_rdata <= ins_ram[ins_rd_ptr];
					tsf_pkg::OFF_INS_CTRL:    host_rdata <= ictl_view;
					default:                  host_rdata <= tsf_pkg::REG_RESET;
				endcase
			end
		end
	end
endmodule // pid_filter_b_port

/* File: verif/host_model.sv */
// Host microcontroller model driving the register strobes of the filter B port
`timescale 1ns/1ps
module host_model
(
	input  wire logic        clock,       // System clock
	output logic      [11:0] host_addr,   // Register byte address
	output logic             host_wr,     // Write strobe
	output logic             host_rd,     // Read strobe
	output logic      [31:0] host_wdata,  // Write data
	input  wire logic [31:0] host_rdata,  // Read data
	input  wire logic        host_rvalid  // Read data valid
);
	// Idle bus at time zero
	initial
	begin
		host_addr <= 12'h000;
		host_wr <= 1'b0;
		host_rd <= 1'b0;
		host_wdata <= 32'h0000_0000;
	end

	// One-cycle write strobe; each call starts on a fresh edge to avoid double drives
	task automatic write(input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		host_addr <= a;
		host_wdata <= d;
		host_wr <= 1'b1;
		@(posedge clock);
		host_wr <= 1'b0;
		host_wdata <= ~d; // Stale data must not be relied on
	endtask

	// One-cycle read strobe; data is taken one edge after the strobe is sampled
	task automatic read(input logic [11:0] a, output logic [31:0] d);
		@(posedge clock);
		host_addr <= a;
		host_rd <= 1'b1;
		@(posedge clock);
		host_rd <= 1'b0;
		@(posedge clock);
		d = host_rdata;
	endtask
endmodule // host_model

/* File: verif/pid_filter_b_port_checker.sv */
// Port-level assertions for the filter B register port
`timescale 1ns/1ps
module pid_filter_b_port_checker
(
	input wire logic        clock,       // System clock
	input wire logic        resetn,      // Synchronous reset
	input wire logic [11:0] host_addr,   // Register address
	input wire logic        host_wr,     // Write strobe
	input wire logic        host_rd,     // Read strobe
	input wire logic [31:0] host_rdata,  // Read data
	input wire logic        host_rvalid, // Read valid
	input wire logic        in_ready,    // Stream ready
	input wire logic        out_valid,   // Buffer word present
	input wire logic        out_ready,   // Buffer takes word
	input wire logic [31:0] out_data,    // Buffer word
	input wire logic [2:0]  out_buffer   // Target buffer
);
	logic csr_hit;
	logic mapped;

	// ==========================================================
	// Address decode helpers
	assign csr_hit = host_rd && host_addr == tsf_pkg::OFF_FILTER_CSR;
	assign mapped = host_addr == tsf_pkg::OFF_FILTER_PORT || host_addr == tsf_pkg::OFF_FILTER_CSR
		|| host_addr == tsf_pkg::OFF_INS_PORT || host_addr == tsf_pkg::OFF_INS_CTRL;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	// ==========================================================
	// Register read timing and content
	a_read_answered: assert property (host_rd |=> host_rvalid)
		else $error("read strobe not answered next cycle");
	a_answer_caused: assert property (host_rvalid |-> $past(host_rd))
		else $error("read valid without a read");
	a_rdata_held: assert property (!host_rvalid |-> $stable(host_rdata))
		else $error("read data changed without a read");
	a_csr_reserved_zero: assert property (csr_hit |=> host_rdata[31:16] == 16'h0000
		&& host_rdata[3:1] == 3'h0)
		else $error("reserved or clear bits read nonzero");
	a_unmapped_zero: assert property (host_rd && !mapped |=> host_rdata == 32'h0000_0000)
		else $error("unmapped read returned data");
	// While on, both table pointers must sit at zero
	a_ptrs_on_zero: assert property ($past(csr_hit) && host_rdata[0] |-> host_rdata[15:8] == 8'h00)
		else $error("table pointer nonzero while filter on");

	// ==========================================================
	// Stream output behaviour
	a_out_stall_hold: assert property (out_valid && !out_ready |=> out_valid
		&& $stable(out_data) && $stable(out_buffer))
		else $error("buffer word changed while stalled");
	a_ready_after_reset: assert property ($rose(resetn) |=> in_ready)
		else $error("stream not ready after reset");

	c_filter_on_read: cover property ($past(csr_hit) && host_rdata[0]);
	c_out_stall: cover property (out_valid && !out_ready);
	c_unmapped_read: cover property (host_rd && !mapped);
endmodule // pid_filter_b_port_checker

bind pid_filter_b_port pid_filter_b_port_checker i_checker
(
	.clock(clock), .resetn(resetn), .host_addr(host_addr), .host_wr(host_wr),
	.host_rd(host_rd), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
	.in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready),
	.out_data(out_data), .out_buffer(out_buffer)
);

/* File: verif/pid_filter_b_port_tb.sv */
// Self-checking testbench for the filter B register port
`timescale 1ns/1ps
module pid_filter_b_port_tb;
	logic        clock;
	logic        resetn;
	logic [11:0] host_addr;
	logic        host_wr;
	logic        host_rd;
	logic [31:0] host_wdata;
	logic [31:0] host_rdata;
	logic        host_rvalid;
	logic        in_valid;
	logic        in_ready;
	logic        in_first;
	logic        in_last;
	logic [12:0] in_pid;
	logic [31:0] in_data;
	logic        out_valid;
	logic        out_ready;
	logic [31:0] out_data;
	logic [2:0]  out_buffer;
	logic [34:0] expq[$];
	logic [31:0] r;
	logic        ok;
	int          n;
	int          n_errors = 0;
	int          check_count = 0;
	int          cycles = 0;

	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	pid_filter_b_port i_dut
	(
		.clock(clock), .resetn(resetn), .host_addr(host_addr), .host_wr(host_wr),
		.host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
		.host_rvalid(host_rvalid), .in_valid(in_valid), .in_ready(in_ready),
		.in_first(in_first), .in_last(in_last), .in_pid(in_pid), .in_data(in_data),
		.out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
		.out_buffer(out_buffer)
	);

	host_model i_host
	(
		.clock(clock), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
		.host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid)
	);

	// ==========================================================
	// Shared checking and stimulus tasks
	task automatic check(input string what, input logic [34:0] seen, input logic [34:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		i_host.read(a, r);
		check("register", {3'h0, r}, {3'h0, exp});
	endtask

	// One stream word; gives up after four edges so a full buffer shows as refusal
	task automatic send(input logic [12:0] pid, input logic [31:0] d, output logic acc);
		@(posedge clock);
		in_valid <= 1'b1;
		in_pid <= pid;
		in_data <= d;
		acc = 1'b0;
		repeat (4)
		begin
			@(posedge clock);
			if (in_ready === 1'b1)
			begin
				acc = 1'b1;
				break;
			end
		end
		in_valid <= 1'b0;
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Drain side: every delivered word must be the next expected one
	always @(posedge clock)
	begin
		if (resetn && out_valid && out_ready)
			check("stream word", {out_buffer, out_data}, expq.size() ? expq.pop_front() : 'x);
	end

	// Hang guard, well above the few hundred cycles the sequence needs
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			final_report();
		end
	end

	// ==========================================================
	// Main sequence
	initial
	begin
		resetn = 1'b0;
		in_valid = 1'b0;
		in_first = 1'b1;
		in_last = 1'b1;
		in_pid = 13'h0000;
		in_data = 32'h0000_0000;
		out_ready = 1'b1;
		repeat (4) @(posedge clock);
		resetn <= 1'b1;
		rdchk(tsf_pkg::OFF_FILTER_CSR, 32'h0000_0000);
		i_host.write(12'h0F0, 32'hFFFF_FFFF);
		rdchk(12'h0F0, 32'h0000_0000);
		i_host.write(tsf_pkg::OFF_FILTER_CSR, 32'hFFFF_FFFE);
		rdchk(tsf_pkg::OFF_FILTER_CSR, 32'h0000_0070);
		for (int i = 0; i < 5; i++)
			i_host.write(tsf_pkg::OFF_FILTER_PORT, 32'h0000_0100 + i);
		rdchk(tsf_pkg::OFF_FILTER_CSR, 32'h0000_0570);
		for (int i = 5; i < 16; i++)
			i_host.write(tsf_pkg::OFF_FILTER_PORT, 32'h0000_0100 + i);
		for (int i = 0; i < 3; i++)
			rdchk(tsf_pkg::OFF_FILTER_PORT, 32'h0000_0100 + i);
		rdchk(tsf_pkg::OFF_FILTER_CSR, 32'h0000_3070);
		// Filter on: pointers forced to zero, reads do not move them
		i_host.write(tsf_pkg::OFF_FILTER_CSR, 32'h0000_0071);
		rdchk(tsf_pkg::OFF_FILTER_CSR, 32'h0000_0071);
		rdchk(tsf_pkg::OFF_FILTER_PORT, 32'h0000_0100);
		rdchk(tsf_pkg::OFF_FILTER_PORT, 32'h0000_0100);
		i_host.write(tsf_pkg::OFF_FILTER_PORT, 32'h0000_DEAD);
		rdchk(tsf_pkg::OFF_FILTER_CSR, 32'h0000_0071);
		expq.push_back({3'h7, 32'h0000_AAAA});
		send(13'h0105, 32'h0000_AAAA, ok);
		send(13'h0050, 32'h0000_BBBB, ok);
		// Two-word packets: the first word's identifier decides for both
		in_last <= 1'b0;
		send(13'h0050, 32'h0000_CCCC, ok);
		in_first <= 1'b0;
		in_last <= 1'b1;
		send(13'h0105, 32'h0000_CCCD, ok);
		in_first <= 1'b1;
		in_last <= 1'b0;
		expq.push_back({3'h7, 32'h0000_CCCE});
		send(13'h0105, 32'h0000_CCCE, ok);
		in_first <= 1'b0;
		in_last <= 1'b1;
		expq.push_back({3'h7, 32'h0000_CCCF});
		send(13'h0050, 32'h0000_CCCF, ok);
		in_first <= 1'b1;
		repeat (10) @(posedge clock);
		check("dropped packet", expq.size(), 0);
		i_host.write(tsf_pkg::OFF_FILTER_CSR, 32'h0000_0070);
		rdchk(tsf_pkg::OFF_FILTER_PORT, 32'h0000_0100);
		// Clear wipes entries and both pointers
		i_host.write(tsf_pkg::OFF_FILTER_PORT, 32'h0000_0055);
		i_host.write(tsf_pkg::OFF_FILTER_CSR, 32'h0000_0072);
		rdchk(tsf_pkg::OFF_FILTER_CSR, 32'h0000_0070);
		rdchk(tsf_pkg::OFF_FILTER_PORT, 32'h0000_0000);
		// Stall the drain and fill the buffer until it refuses
		out_ready <= 1'b0;
		n = 0;
		ok = 1'b1;
		while (ok && n < 20)
		begin
			expq.push_back({3'h7, 32'h0000_00D0 + n});
			send(13'h0050, 32'h0000_00D0 + n, ok);
			if (ok)
				n++;
			else
				void'(expq.pop_back());
		end
		check("fill refused", {34'h0, ok}, 35'h0);
		check("fill depth", {34'h0, n >= tsf_pkg::FIFO_DEPTH}, 35'h1);
		// Load the insertion packet before enabling it
		for (int i = 0; i < 3; i++)
			i_host.write(tsf_pkg::OFF_INS_PORT, 32'h0000_00C0 + i);
		i_host.read(tsf_pkg::OFF_INS_CTRL, r);
		check("insert write pointer", {29'h0, r[29:24]}, 35'h3);
		i_host.write(tsf_pkg::OFF_INS_CTRL, 32'h0000_0243);
		i_host.write(tsf_pkg::OFF_INS_PORT, 32'h0000_0BAD);
		i_host.read(tsf_pkg::OFF_INS_CTRL, r);
		check("insert enabled", {3'h0, r & 32'h3F00_0040}, 35'h40);
		for (int i = 0; i < 3; i++)
			expq.push_back({3'h2, 32'h0000_00C0 + i});
		out_ready <= 1'b1;
		n = 0;
		while (expq.size() != 0 && n < 200)
		begin
			@(posedge clock);
			n++;
		end
		check("drained", expq.size(), 0);
		repeat (5) @(posedge clock);
		i_host.read(tsf_pkg::OFF_INS_CTRL, r);
		check("insert self clear", {34'h0, r[6]}, 35'h0);
		// Wrap the insertion write pointer, then reset both pointers and read back
		for (int i = 0; i < 65; i++)
			i_host.write(tsf_pkg::OFF_INS_PORT, 32'h0000_0E00 + i);
		i_host.read(tsf_pkg::OFF_INS_CTRL, r);
		check("insert pointer wrap", {29'h0, r[29:24]}, 35'h1);
		i_host.write(tsf_pkg::OFF_INS_CTRL, 32'h4040_0203);
		rdchk(tsf_pkg::OFF_INS_PORT, 32'h0000_0E40);
		rdchk(tsf_pkg::OFF_INS_PORT, 32'h0000_0E01);
		i_host.read(tsf_pkg::OFF_INS_CTRL, r);
		check("insert pointers", {3'h0, r & 32'h3F3F_0000}, 35'h0002_0000);
		final_report();
	end
endmodule // pid_filter_b_port_tb
